// File: gpc_config_top.sv
// gain, pulse output and phase calibration registers behind AXI4-Lite
//
// Functional notes
// R01: phase current gain code, 101+ act as 000
// R02: neutral gain code in bits 5:3
// R03: voltage gain code in bits 8:6
// R04: pulse one quantity select, reset 000
// R05: pulse two select bits 5:3, reset 100
// R06: pulse three select bits 8:6, reset 010
// R07: only included phases summed, all by default
// R08: pulse one pin disable bit 9, reset 1
// R09: pulse two pin disable bit 10, reset 1
// R10: pulse three pin disable bit 11, reset 1
// R11: pulse one pulse captures energy, bit 12
// R12: pulse two pulse captures energy, bit 13
// R13: pulse three pulse captures energy, bit 14
// R14: software keeps current compensation 0 to 383
// R15: software keeps voltage compensation 512 to 575
// R16: values 384-511 act as 256-383
// R17: values 576-1023 act as 384-511
// R18: sixteen-bit registers, reserved bits read zero
`timescale 1ns/1ps
module gpc_config_top #(
    parameter int EW = 32
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [`GPC_AXI_AW-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`GPC_AXI_AW-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire gpc_pkg::gpc_phase_power_t [2:0] phase_power,
    input wire logic [2:0] dfc_pulse,
    input wire logic [2:0][EW-1:0] energy_in,
    output logic pulse_output_one,
    output logic pulse_output_two,
    output logic pulse_output_three,
    output logic signed [2:0][`GPC_POWER_W+1:0] pulse_sum_power,
    output logic [2:0][EW-1:0] energy_snapshot,
    output logic [2:0] energy_snapshot_strobe,
    output gpc_pkg::gpc_gain_codes_t gain_codes,
    output gpc_pkg::gpc_gain_factors_t gain_factors,
    output logic [2:0][`GPC_CAL_W-1:0] phase_compensation_value,
    output logic [2:0] compensation_on_voltage
);
    import gpc_pkg::*;

    // ------------
    // helpers
    // ------------
    localparam logic [2:0] SEL_GAIN = 3'h0;
    localparam logic [2:0] SEL_PULSE = 3'h1;
    localparam logic [2:0] SEL_CAL_A = 3'h2;
    localparam logic [2:0] SEL_CAL_B = 3'h3;
    localparam logic [2:0] SEL_CAL_C = 3'h4;
    localparam logic [2:0] SEL_INCLUDE = 3'h5;
    localparam logic [2:0] SEL_STATUS = 3'h6;
    localparam logic [2:0] SEL_NONE = 3'h7;

    // low two address bits are ignored: every register is a whole word
    function automatic logic [2:0] decode(
        input logic [`GPC_AXI_AW-1:0] addr
    );
        logic [15:0] idx;
        idx = addr[`GPC_AXI_AW-1:2];
        case (idx)
            `GPC_IDX_GAIN: decode = SEL_GAIN;
            `GPC_IDX_PULSE: decode = SEL_PULSE;
            `GPC_IDX_CAL_A: decode = SEL_CAL_A;
            `GPC_IDX_CAL_B: decode = SEL_CAL_B;
            `GPC_IDX_CAL_C: decode = SEL_CAL_C;
            `GPC_IDX_INCLUDE: decode = SEL_INCLUDE;
            `GPC_IDX_STATUS: decode = SEL_STATUS;
            default: decode = SEL_NONE;
        endcase
    endfunction

    function automatic logic [15:0] merge(
        input logic [15:0] old,
        input logic [31:0] data,
        input logic [3:0] strb,
        input logic [15:0] mask
    );
        logic [15:0] v;
        v = old;
        if (strb[0]) begin
            v[7:0] = data[7:0];
        end
        if (strb[1]) begin
            v[15:8] = data[15:8];
        end
        merge = v & mask; // R18
    endfunction

    // reserved codes behave like code 000
    function automatic logic [2:0] gain_code(input logic [2:0] raw);
        gain_code = (raw > `GPC_GAIN_CODE_MAX) ? 3'h0 : raw;
    endfunction

    function automatic logic [4:0] gain_factor(input logic [2:0] code);
        gain_factor = 5'h01 << code;
    endfunction

    // 576 and up fold back into 384-511, which in turn acts as 256-383
    function automatic logic [`GPC_CAL_W-1:0] cal_effective(
        input logic [`GPC_CAL_W-1:0] raw
    );
        logic [`GPC_CAL_W-1:0] off;
        off = raw - `GPC_CAL_ALIAS2_BASE;
        if (raw <= `GPC_CAL_CUR_MAX) begin
            cal_effective = raw;
        end else if (raw <= `GPC_CAL_ALIAS1_MAX) begin
            cal_effective = raw - `GPC_CAL_ALIAS1_SHIFT; // R16
        end else if (raw <= `GPC_CAL_VOL_MAX) begin
            cal_effective = raw;
        end else begin
            cal_effective = `GPC_CAL_ALIAS2_TARGET +
                            (off & `GPC_CAL_ALIAS2_SPAN); // R17
        end
    endfunction

    // ------------
    // configuration registers
    // ------------
    logic [15:0] gain_reg;
    logic [15:0] pulse_reg;
    logic [2:0][15:0] cal_reg;
    logic [15:0] include_reg;
    logic [2:0] pin_level;

    // ------------
    // write path
    // ------------
    logic aw_held;
    logic w_held;
    logic [`GPC_AXI_AW-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    wire logic aw_take;
    wire logic w_take;
    wire logic do_write;
    wire logic [2:0] wsel;
    wire logic [15:0] next_gain;
    wire logic [15:0] next_pulse;
    wire logic [15:0] next_include;

    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign do_write = aw_held & w_held & ~s_axi_bvalid;
    assign wsel = decode(aw_addr);
    assign next_gain = merge(gain_reg, w_data, w_strb, `GPC_GAIN_MASK);
    assign next_pulse = merge(pulse_reg, w_data, w_strb, `GPC_PULSE_MASK);
    assign next_include = merge(include_reg, w_data, w_strb,
                                `GPC_INCLUDE_MASK);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (w_take) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `GPC_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wsel == SEL_NONE) ? `GPC_RESP_SLVERR
                                              : `GPC_RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gain_reg <= `GPC_GAIN_RST; // R01
            pulse_reg <= `GPC_PULSE_RST; // R04 R05 R06 R08 R09 R10
            include_reg <= `GPC_INCLUDE_RST; // R07
        end else if (do_write) begin
            if (wsel == SEL_GAIN) begin
                gain_reg <= next_gain;
            end
            if (wsel == SEL_PULSE) begin
                pulse_reg <= next_pulse;
            end
            if (wsel == SEL_INCLUDE) begin
                include_reg <= next_include;
            end
        end
    end

    // out-of-range values are stored raw, aliased later
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cal_reg <= {3{`GPC_CAL_RST}};
        end else if (do_write) begin
            for (int i = 0; i < 3; i++) begin
                if (wsel == SEL_CAL_A + 3'(i)) begin
                    cal_reg[i] <= merge(cal_reg[i], w_data, w_strb,
                                        `GPC_CAL_MASK); // R18
                end
            end
        end
    end

    // ------------
    // read path
    // ------------
    wire logic ar_take;
    wire logic [2:0] rsel;
    logic [15:0] read_word;

    assign s_axi_arready = ~s_axi_rvalid;
    assign ar_take = s_axi_arvalid & s_axi_arready;
    assign rsel = decode(s_axi_araddr);

    always_comb begin
        read_word = 16'h0000;
        case (rsel)
            SEL_GAIN: read_word = gain_reg;
            SEL_PULSE: read_word = pulse_reg;
            SEL_CAL_A: read_word = cal_reg[0];
            SEL_CAL_B: read_word = cal_reg[1];
            SEL_CAL_C: read_word = cal_reg[2];
            SEL_INCLUDE: read_word = include_reg;
            SEL_STATUS: read_word = {10'h000, energy_snapshot_strobe,
                                     pin_level};
            default: read_word = 16'h0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `GPC_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, read_word}; // R18
            s_axi_rresp <= (rsel == SEL_NONE) ? `GPC_RESP_SLVERR
                                              : `GPC_RESP_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------
    // gain and calibration outputs
    // ------------
    wire gpc_gain_codes_t next_codes;
    wire gpc_gain_factors_t next_factors;

    assign next_codes.phase_current =
        gain_code(gain_reg[`GPC_GAIN_PHI_LSB +: 3]); // R01
    assign next_codes.neutral_current =
        gain_code(gain_reg[`GPC_GAIN_NEU_LSB +: 3]); // R02
    assign next_codes.phase_voltage =
        gain_code(gain_reg[`GPC_GAIN_VOL_LSB +: 3]); // R03
    assign next_factors.phase_current =
        gain_factor(next_codes.phase_current);
    assign next_factors.neutral_current =
        gain_factor(next_codes.neutral_current);
    assign next_factors.phase_voltage =
        gain_factor(next_codes.phase_voltage);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gain_codes <= '0;
            gain_factors <= '0;
            phase_compensation_value <= '0;
            compensation_on_voltage <= '0;
        end else begin
            gain_codes <= next_codes;
            gain_factors <= next_factors;
            for (int i = 0; i < 3; i++) begin
                phase_compensation_value[i] <=
                    cal_effective(cal_reg[i][`GPC_CAL_W-1:0]);
                compensation_on_voltage[i] <=
                    cal_reg[i][`GPC_CAL_W-1:0] > `GPC_CAL_ALIAS1_MAX &&
                    cal_reg[i][`GPC_CAL_W-1:0] <= `GPC_CAL_VOL_MAX;
            end
        end
    end

    // ------------
    // pulse outputs
    // ------------
    gpc_pulse_cfg_t [2:0] chan_cfg;

    always_comb begin
        chan_cfg = '0;
        for (int i = 0; i < 3; i++) begin
            chan_cfg[i].quantity_select =
                pulse_reg[`GPC_SEL_LSB + 3*i +: 3]; // R04 R05 R06
            chan_cfg[i].phase_include = include_reg[3*i +: 3]; // R07
            chan_cfg[i].pin_disable =
                pulse_reg[`GPC_DIS_LSB + i]; // R08 R09 R10
            chan_cfg[i].energy_capture =
                pulse_reg[`GPC_CAP_LSB + i]; // R11 R12 R13
        end
    end

    for (genvar g = 0; g < 3; g++) begin : g_chan
        gpc_pulse_channel #(
            .EW(EW)
        ) u_chan (
            .clk(clk),
            .sys_rst(sys_rst),
            .phase_power(phase_power),
            .cfg(chan_cfg[g]),
            .dfc_pulse(dfc_pulse[g]),
            .energy_in(energy_in[g]),
            .pin(pin_level[g]),
            .sum_power(pulse_sum_power[g]),
            .energy_snapshot(energy_snapshot[g]),
            .snapshot_strobe(energy_snapshot_strobe[g])
        );
    end

    assign pulse_output_one = pin_level[0];
    assign pulse_output_two = pin_level[1];
    assign pulse_output_three = pin_level[2];
endmodule

// File: gpc_defines.svh
// register indices, field positions, reset values and codes for gpc
`ifndef GPC_DEFINES_SVH
`define GPC_DEFINES_SVH

// ------------
// register indices (byte address is four times the index)
// ------------
`define GPC_IDX_GAIN 16'he60f
`define GPC_IDX_PULSE 16'he610
`define GPC_IDX_CAL_A 16'he614
`define GPC_IDX_CAL_B 16'he615
`define GPC_IDX_CAL_C 16'he616
`define GPC_IDX_INCLUDE 16'he620
`define GPC_IDX_STATUS 16'he621
`define GPC_AXI_AW 18

// ------------
// field positions
// ------------
`define GPC_GAIN_PHI_LSB 0
`define GPC_GAIN_NEU_LSB 3
`define GPC_GAIN_VOL_LSB 6
`define GPC_SEL_LSB 0
`define GPC_DIS_LSB 9
`define GPC_CAP_LSB 12
`define GPC_CAL_W 10

// ------------
// writable masks and reset values
// ------------
`define GPC_GAIN_MASK 16'h01ff
`define GPC_PULSE_MASK 16'h7fff
`define GPC_CAL_MASK 16'h03ff
`define GPC_INCLUDE_MASK 16'h01ff
`define GPC_GAIN_RST 16'h0000
`define GPC_PULSE_RST 16'h0ea0
`define GPC_CAL_RST 16'h0000
`define GPC_INCLUDE_RST 16'h01ff

// ------------
// codes and calibration ranges
// ------------
`define GPC_Q_TOTAL_ACTIVE 3'h0
`define GPC_Q_APPARENT 3'h2
`define GPC_Q_FUND_ACTIVE 3'h3
`define GPC_Q_FUND_REACTIVE 3'h4
`define GPC_GAIN_CODE_MAX 3'h4
`define GPC_CAL_CUR_MAX 10'h17f
`define GPC_CAL_ALIAS1_MAX 10'h1ff
`define GPC_CAL_VOL_MAX 10'h23f
`define GPC_CAL_ALIAS1_SHIFT 10'h080
`define GPC_CAL_ALIAS2_BASE 10'h240
`define GPC_CAL_ALIAS2_TARGET 10'h100
`define GPC_CAL_ALIAS2_SPAN 10'h07f
`define GPC_POWER_W 24
`define GPC_RESP_OKAY 2'h0
`define GPC_RESP_SLVERR 2'h2

`endif

// File: gpc_pkg.sv
// types shared by the gpc configuration block
package gpc_pkg;
    `include "gpc_defines.svh"

    typedef enum logic [2:0] {
        GPC_Q_TOTAL_ACTIVE = `GPC_Q_TOTAL_ACTIVE,
        GPC_Q_APPARENT = `GPC_Q_APPARENT,
        GPC_Q_FUND_ACTIVE = `GPC_Q_FUND_ACTIVE,
        GPC_Q_FUND_REACTIVE = `GPC_Q_FUND_REACTIVE
    } gpc_quantity_t;

    typedef struct packed {
        logic signed [`GPC_POWER_W-1:0] total_active;
        logic signed [`GPC_POWER_W-1:0] apparent;
        logic signed [`GPC_POWER_W-1:0] fund_active;
        logic signed [`GPC_POWER_W-1:0] fund_reactive;
    } gpc_phase_power_t;

    typedef struct packed {
        logic [2:0] quantity_select;
        logic [2:0] phase_include;
        logic pin_disable;
        logic energy_capture;
    } gpc_pulse_cfg_t;

    typedef struct packed {
        logic [2:0] phase_current;
        logic [2:0] neutral_current;
        logic [2:0] phase_voltage;
    } gpc_gain_codes_t;

    typedef struct packed {
        logic [4:0] phase_current;
        logic [4:0] neutral_current;
        logic [4:0] phase_voltage;
    } gpc_gain_factors_t;
endpackage

// File: gpc_pulse_channel.sv
// one pulse output: quantity pick, phase sum, pin gate, energy capture
`timescale 1ns/1ps
module gpc_pulse_channel #(
    parameter int EW = 32
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire gpc_pkg::gpc_phase_power_t [2:0] phase_power,
    input wire gpc_pkg::gpc_pulse_cfg_t cfg,
    input wire logic dfc_pulse,
    input wire logic [EW-1:0] energy_in,
    output logic pin,
    output logic signed [`GPC_POWER_W+1:0] sum_power,
    output logic [EW-1:0] energy_snapshot,
    output logic snapshot_strobe
);
    import gpc_pkg::*;

    // ------------
    // quantity selection
    // ------------
    // reserved codes contribute nothing rather than a stale quantity
    function automatic logic signed [`GPC_POWER_W+1:0] pick(
        input gpc_phase_power_t p,
        input logic [2:0] sel,
        input logic use_phase
    );
        logic signed [`GPC_POWER_W-1:0] v;
        v = '0;
        case (sel)
            `GPC_Q_TOTAL_ACTIVE: v = p.total_active;
            `GPC_Q_APPARENT: v = p.apparent;
            `GPC_Q_FUND_ACTIVE: v = p.fund_active;
            `GPC_Q_FUND_REACTIVE: v = p.fund_reactive;
            default: v = '0;
        endcase
        pick = use_phase ? (`GPC_POWER_W+2)'(v) : '0;
    endfunction

    wire logic signed [`GPC_POWER_W+1:0] term_a;
    wire logic signed [`GPC_POWER_W+1:0] term_b;
    wire logic signed [`GPC_POWER_W+1:0] term_c;
    wire logic signed [`GPC_POWER_W+1:0] next_sum_power;
    wire logic next_pin;
    wire logic next_capture;

    assign term_a = pick(phase_power[0], cfg.quantity_select,
                         cfg.phase_include[0]); // R07
    assign term_b = pick(phase_power[1], cfg.quantity_select,
                         cfg.phase_include[1]); // R07
    assign term_c = pick(phase_power[2], cfg.quantity_select,
                         cfg.phase_include[2]); // R07
    assign next_sum_power = term_a + term_b + term_c;
    // converter keeps running; only the pin is held low
    assign next_pin = dfc_pulse & ~cfg.pin_disable;
    assign next_capture = dfc_pulse & cfg.energy_capture;

    // ------------
    // registers
    // ------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin <= 1'b0;
            sum_power <= '0;
            snapshot_strobe <= 1'b0;
        end else begin
            pin <= next_pin;
            sum_power <= next_sum_power;
            snapshot_strobe <= next_capture;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            energy_snapshot <= '0;
        end else if (next_capture) begin
            energy_snapshot <= energy_in;
        end
    end
endmodule

// File: gpc_config_monitor.sv
// assertion checker for the gpc configuration block
`timescale 1ns/1ps
module gpc_config_monitor
    import gpc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [2:0] dfc_pulse,
    input wire logic pulse_output_one,
    input wire logic pulse_output_two,
    input wire logic pulse_output_three,
    input wire logic [2:0] energy_snapshot_strobe,
    input wire gpc_pkg::gpc_gain_codes_t gain_codes,
    input wire gpc_pkg::gpc_gain_factors_t gain_factors
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // derived outputs lag reset release by one edge
    logic [1:0] age;
    always_ff @(posedge clk) begin
        if (sys_rst) age <= 2'h0;
        else if (age != 2'h3) age <= age + 2'h1;
    end
    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_r_wait;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
        else $error("read not answered");
    a_read_holds: assert property (s_r_wait |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
    a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    a_pin_one_cause: assert property (
        pulse_output_one |-> $past(dfc_pulse[0])) else $error("pin one");
    a_pin_two_cause: assert property (
        pulse_output_two |-> $past(dfc_pulse[1])) else $error("pin two");
    a_pin_three_cause: assert property (
        pulse_output_three |-> $past(dfc_pulse[2])) else $error("pin three");
    a_capture_cause: assert property (
        (energy_snapshot_strobe & ~$past(dfc_pulse)) == 3'h0)
        else $error("capture without pulse");
    a_gain_code_range: assert property (
        gain_codes.phase_current <= 3'h4 && gain_codes.neutral_current
        <= 3'h4 && gain_codes.phase_voltage <= 3'h4) else $error("gain code");
    a_gain_factor_match: assert property (
        age == 2'h3 && $stable(gain_codes) |-> gain_factors ==
        {5'h1 << gain_codes.phase_current, 5'h1 << gain_codes.neutral_current,
        5'h1 << gain_codes.phase_voltage}) else $error("gain factor");
endmodule
bind gpc_config_top gpc_config_monitor u_mon (.*);

// File: test_gpc_config_top.sv
// self-checking testbench for the gpc configuration block
`timescale 1ns/1ps
`include "gpc_defines.svh"
module test_gpc_config_top;
    import gpc_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    // responses are always taken at once
    logic s_axi_bready = 1, s_axi_rready = 1;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    gpc_phase_power_t [2:0] phase_power;
    logic [2:0] dfc_pulse = '0;
    logic [2:0][31:0] energy_in = '0, energy_snapshot;
    logic pulse_output_one, pulse_output_two, pulse_output_three;
    logic signed [2:0][`GPC_POWER_W+1:0] pulse_sum_power;
    logic [2:0] energy_snapshot_strobe, compensation_on_voltage;
    gpc_gain_codes_t gain_codes;
    gpc_gain_factors_t gain_factors;
    logic [2:0][9:0] phase_compensation_value;
    int n_fail = 0, tests_run = 0;
    int pq[3][4] = '{'{-1000, 2000, 300, -7}, '{-2500, 2100, 600, -8},
        '{-3000, 2200, 900, 9}};

    gpc_config_top #(.EW(32)) DUT (.clk, .sys_rst, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .phase_power, .dfc_pulse, .energy_in,
        .pulse_output_one, .pulse_output_two, .pulse_output_three,
        .pulse_sum_power, .energy_snapshot, .energy_snapshot_strobe,
        .gain_codes, .gain_factors, .phase_compensation_value,
        .compensation_on_voltage);

    always #50 clk = ~clk;

    // ------------
    // helpers
    // ------------
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [2:0] ge(input logic [2:0] x);
        return (x > 3'h4) ? 3'h0 : x;
    endfunction
    function automatic logic [25:0] esum(input logic [2:0] c, inc);
        int s;
        int q;
        s = 0;
        q = (c == 3'h0) ? 0 : (c == 3'h2) ? 1 : (c == 3'h3) ? 2 : 3;
        for (int p = 0; p < 3; p++)
            if (inc[p] && (c == 3'h0 || c[2:1] != 2'h0) && c <= 3'h4) s += pq[p][q];
        return 26'(s);
    endfunction
    task automatic axi_wr(input logic [15:0] idx, input logic [31:0] d,
                          output logic [1:0] r);
        logic a, w, b;
        {a, w} = 2'b11;
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
        // handshakes judged on settled values, just before the edge
        do begin
            @(negedge clk);
            a &= !s_axi_awready;
            w &= !s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk);
            if (!b) {s_axi_awvalid, s_axi_wvalid} <= {a, w};
        end while (!b);
    endtask
    task automatic axi_rd(input logic [15:0] idx, output logic [31:0] d,
                          output logic [1:0] r);
        logic a, b;
        a = 1'b1;
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        do begin
            @(negedge clk);
            a &= !s_axi_arready;
            b = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (!b) s_axi_arvalid <= a;
        end while (!b);
    endtask
    task automatic rchk(input string nm, input logic [15:0] i, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(i, d, r);
        chk(nm, d, e);
        chk("rresp", {30'h0, r}, `GPC_RESP_OKAY);
    endtask

    // ------------
    // scenarios
    // ------------
    task automatic t_reset;
        rchk("gain", `GPC_IDX_GAIN, 32'h0);
        rchk("pulse", `GPC_IDX_PULSE, 32'h0ea0);
        rchk("include", `GPC_IDX_INCLUDE, 32'h1ff);
        for (int p = 0; p < 3; p++) rchk("cal", 16'(`GPC_IDX_CAL_A + p), 32'h0);
        chk("sum1", pulse_sum_power[0][25:0], esum(3'h0, 3'h7));
        chk("sum2", pulse_sum_power[1][25:0], esum(3'h4, 3'h7));
        chk("sum3", pulse_sum_power[2][25:0], esum(3'h2, 3'h7));
    endtask
    task automatic t_gain;
        logic [1:0] r;
        logic [2:0] a, b, g;
        // distinct field codes expose swapped fields
        for (int c = 0; c < 8; c++) begin
            a = 3'(c);
            b = 3'(7 - c);
            g = a ^ 3'h2;
            axi_wr(`GPC_IDX_GAIN, {16'hffff, 7'h7f, g, b, a}, r);
            chk("bresp", {30'h0, r}, `GPC_RESP_OKAY);
            repeat (3) @(posedge clk);
            rchk("gain rb", `GPC_IDX_GAIN, {23'h0, g, b, a});
            chk("codes", gain_codes, {ge(a), ge(b), ge(g)});
            chk("factors", gain_factors, {5'h1 << ge(a), 5'h1 << ge(b),
                5'h1 << ge(g)});
        end
    endtask
    task automatic t_pulse;
        logic [1:0] r;
        logic [2:0] cs[6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h1, 3'h5};
        axi_wr(`GPC_IDX_INCLUDE, 32'h1d9, r);
        for (int k = 0; k < 6; k++) begin
            axi_wr(`GPC_IDX_PULSE, {cs[(k+2)%6], cs[(k+1)%6], cs[k]} | 32'h0e00, r);
            repeat (3) @(posedge clk);
            for (int i = 0; i < 3; i++)
                chk("sum", pulse_sum_power[i][25:0], esum(cs[(k+i)%6],
                    3'(32'h1d9 >> (3 * i))));
        end
    endtask
    task automatic t_pins;
        logic [1:0] r;
        logic [15:0] cf[4] = '{16'h0ea0, 16'h7000, 16'h7e00, 16'h2a00};
        for (int k = 0; k < 4; k++) begin
            axi_wr(`GPC_IDX_PULSE, {16'h0, cf[k]}, r);
            energy_in <= {32'hc0 + k, 32'hb0 + k, 32'ha0 + k};
            dfc_pulse <= 3'h7;
            @(posedge clk);
            dfc_pulse <= 3'h0;
            @(negedge clk);
            chk("pins", {pulse_output_three, pulse_output_two,
                pulse_output_one}, 3'(~cf[k][11:9]));
            chk("strobe", energy_snapshot_strobe, cf[k][14:12]);
            for (int i = 0; i < 3; i++)
                if (cf[k][12+i]) chk("snap", energy_snapshot[i], energy_in[i]);
            @(posedge clk);
        end
    endtask
    task automatic t_cal;
        logic [1:0] r;
        logic [9:0] v[8] = '{10'h064, 10'h17f, 10'h180, 10'h1ff, 10'h200,
            10'h23f, 10'h240, 10'h3ff};
        logic [9:0] e[8] = '{10'h064, 10'h17f, 10'h100, 10'h17f, 10'h200,
            10'h23f, 10'h100, 10'h13f};
        for (int k = 0; k < 8; k++) begin
            axi_wr(16'(`GPC_IDX_CAL_A + k % 3), {22'h3fffff, v[k]}, r);
            repeat (3) @(posedge clk);
            rchk("cal rb", 16'(`GPC_IDX_CAL_A + k % 3), {22'h0, v[k]});
            chk("cal", phase_compensation_value[k % 3], e[k]);
            chk("volt", compensation_on_voltage[k % 3], v[k] inside
                {[10'h200:10'h23f]});
        end
    endtask
    task automatic t_unmapped;
        logic [1:0] r;
        logic [31:0] d;
        axi_wr(16'h0001, 32'hffff, r);
        chk("wr err", {30'h0, r}, `GPC_RESP_SLVERR);
        axi_rd(16'h0001, d, r);
        chk("rd err", {30'h0, r}, `GPC_RESP_SLVERR);
        chk("rd data", d, 32'h0);
    endtask

    initial begin
        foreach (pq[p]) phase_power[p] = {24'(pq[p][0]), 24'(pq[p][1]),
            24'(pq[p][2]), 24'(pq[p][3])};
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_gain;
        t_pulse;
        t_pins;
        t_cal;
        t_unmapped;
        close_out;
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        close_out;
    end
endmodule
